/* tmb_timer_dev.sv */
// Type B 16-bit timer: periodic, time-out check and capture modes
//
// Summary of operation
// - zero count is the restart point
// - all-ones count wraps with overflow indication
// - top is the compare/capture register value
// - clock from prescaler, companion timer or event
// - companion clock steps counter with companion timer
// - event counting needs event channel clock source
// - periodic mode is the reset mode
// - enable bit starts counting on selected ticks
// - output enable puts waveform over port value
// - periodic: flag at top, then restart zero
// - top below count: run to max, wrap
// - event pulses last longer than one clock
// - time-out: start edge runs, stop edge freezes
// - edge bit picks start and stop polarity
// - time-out: capture flag when top reached
// - frozen: count reads, run writes change nothing
// - software enables event use before event modes
// - capture: free run, copy count on event
// - capture edge selectable rising or falling
// - capture mode: low byte read clears flag
// - capture mode: overflow flag at max
// - software clears count entering capture mode
// - status shows whether counter is counting
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tmb_timer_dev (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  tmb_link_if.dev     link,
  output logic [15:0] count_o,
  output logic        run_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  control_a_q;
  logic [7:0]  control_b_q;
  logic [7:0]  event_control_q;
  logic [1:0]  flag_q;
  logic [1:0]  flag_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] compare_capture_value_q;
  logic [15:0] compare_capture_value_d;
  logic        run_q;
  logic        run_d;
  logic        div_q;
  logic        wo_q;
  logic        pin_q;
  logic        capture_flag_q;
  logic        wrap_q;
  logic        ack_q;
  logic        run_out_q;
  logic [15:0] rdata_q;
  logic        ev_rise;
  logic        ev_fall;

  // Event edges
  tmb_edge_det u_edge (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .lvl_i  (link.evt_lvl),
    .rise_o (ev_rise),
    .fall_o (ev_fall)
  );

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  wire wr        = link.reg_req & link.reg_we;
  wire rd        = link.reg_req & ~link.reg_we;
  wire wr_lo     = wr & link.reg_be[0];
  wire wr_hi     = wr & link.reg_be[1];
  wire sel_control_a = link.reg_addr == tmb_pkg::DEV_CONTROL_A;
  wire sel_control_b = link.reg_addr == tmb_pkg::DEV_CONTROL_B;
  wire sel_evc   = link.reg_addr == tmb_pkg::DEV_EVENT_CONTROL;
  wire sel_flags = link.reg_addr == tmb_pkg::DEV_FLAGS;
  wire sel_stat  = link.reg_addr == tmb_pkg::DEV_STATUS;
  wire sel_cnt   = link.reg_addr == tmb_pkg::DEV_CNT;
  wire sel_compare_capture_value  = link.reg_addr == tmb_pkg::DEV_COMPARE_CAPTURE_VALUE;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  wire       enable   = control_a_q[tmb_pkg::CONTROL_A_EN_BIT];
  wire [1:0] csel     = control_a_q[tmb_pkg::CONTROL_A_CSEL_LSB +: 2];
  wire [1:0] mode     = control_b_q[tmb_pkg::CONTROL_B_MODE_LSB +: 2];
  wire       oen      = control_b_q[tmb_pkg::CONTROL_B_OEN_BIT];
  wire       ev_user  = event_control_q[tmb_pkg::EVENT_CONTROL_EI_BIT];
  wire       edge_sel = event_control_q[tmb_pkg::EVENT_CONTROL_EDGE_BIT];
  wire       is_to    = mode == tmb_pkg::MODE_TIMEOUT;
  wire       is_cap   = mode == tmb_pkg::MODE_CAPTURE;
  wire       is_per   = ~is_to & ~is_cap;

  // Tick selection
  wire tick_div  = (csel == tmb_pkg::CSEL_DIV1) | ((csel == tmb_pkg::CSEL_DIV2) & div_q);
  wire tick_comp = (csel == tmb_pkg::CSEL_COMP) & link.comp_tick;
  wire tick_evt  = (csel == tmb_pkg::CSEL_EVENT) & ev_rise;
  wire tick      = enable & (tick_div | tick_comp | tick_evt);

  // Event actions, only for an enabled event user
  wire ev_ok      = enable & ev_user;
  wire start_edge = ev_ok & (edge_sel ? ev_fall : ev_rise);
  wire stop_edge  = ev_ok & (edge_sel ? ev_rise : ev_fall);

  // Count conditions
  wire counting = is_to ? run_q : enable;
  wire step     = tick & counting;
  wire at_top   = cnt_q == compare_capture_value_q;
  wire at_max   = cnt_q == tmb_pkg::CNT_MAX;
  wire capture_flag_hit = (step & at_top & ~is_cap) | (is_cap & start_edge);
  wire wrap_hit = step & at_max & (~is_per | ~at_top);
  wire restart  = step & ((is_per & at_top) | at_max);
  wire to_start = is_to & ~run_q & start_edge;
  wire to_stop  = is_to & run_q & stop_edge;

  // Flag clears: write one, or capture-mode low byte read
  wire clr_w1   = wr_lo & sel_flags;
  wire clr_rd   = rd & sel_compare_capture_value & link.reg_be[0] & is_cap;
  wire [1:0] flag_clr = (clr_w1 ? link.reg_wdata[1:0] : 2'h0)
                      | {1'b0, clr_rd};
  wire [1:0] flag_set = {wrap_hit, capture_flag_hit};

  // Readback mux
  wire [15:0] rd_mux =
      sel_control_a ? {8'h00, control_a_q} :
      sel_control_b ? {8'h00, control_b_q} :
      sel_evc   ? {8'h00, event_control_q} :
      sel_flags ? {14'h0000, flag_q} :
      sel_stat  ? {15'h0000, counting} :
      sel_cnt   ? cnt_q :
      sel_compare_capture_value  ? compare_capture_value_q : 16'h0000;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Counter: software write wins over counting
  always_comb
  begin
    cnt_d = cnt_q;
    if (to_start)
      cnt_d = tmb_pkg::CNT_BOTTOM;
    else if (restart)
      cnt_d = tmb_pkg::CNT_BOTTOM;
    else if (step)
      cnt_d = cnt_q + tmb_pkg::CNT_STEP;
    if (wr_lo & sel_cnt)
      cnt_d[7:0] = link.reg_wdata[7:0];
    if (wr_hi & sel_cnt)
      cnt_d[15:8] = link.reg_wdata[15:8];
  end

  // Compare/capture value
  always_comb
  begin
    compare_capture_value_d = compare_capture_value_q;
    if (is_cap & start_edge)
      compare_capture_value_d = cnt_q;
    if (wr_lo & sel_compare_capture_value)
      compare_capture_value_d[7:0] = link.reg_wdata[7:0];
    if (wr_hi & sel_compare_capture_value)
      compare_capture_value_d[15:8] = link.reg_wdata[15:8];
  end

  // Time-out run state; status is read only, frozen stays frozen
  always_comb
  begin
    run_d = run_q;
    if (!is_to || !enable)
      run_d = 1'b0;
    else if (to_start)
      run_d = 1'b1;
    else if (to_stop)
      run_d = 1'b0;
  end

  // Sticky flags, set wins over clear
  assign flag_d = (flag_q & ~flag_clr) | flag_set;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      control_a_q  <= tmb_pkg::REG8_RESET;
      control_b_q  <= tmb_pkg::REG8_RESET;
      event_control_q <= tmb_pkg::REG8_RESET;
    end
    else
    begin
      if (wr_lo & sel_control_a)
        control_a_q <= link.reg_wdata[7:0];
      if (wr_lo & sel_control_b)
        control_b_q <= link.reg_wdata[7:0];
      if (wr_lo & sel_evc)
        event_control_q <= link.reg_wdata[7:0];
    end
  end

  // Count state and flags
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cnt_q  <= tmb_pkg::CNT_BOTTOM;
      compare_capture_value_q <= tmb_pkg::CNT_BOTTOM;
      run_q  <= 1'b0;
      flag_q <= 2'h0;
      div_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      compare_capture_value_q <= compare_capture_value_d;
      run_q  <= run_d;
      flag_q <= flag_d;
      div_q  <= ~div_q;
    end
  end

  // Events, waveform pin and register answer
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      capture_flag_q  <= 1'b0;
      wrap_q  <= 1'b0;
      wo_q    <= 1'b0;
      pin_q   <= 1'b0;
      ack_q   <= 1'b0;
      run_out_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      capture_flag_q <= capture_flag_hit;
      wrap_q <= wrap_hit;
      wo_q   <= control_b_q[tmb_pkg::CONTROL_B_INIT_BIT];
      pin_q  <= oen ? wo_q : link.port_val;
      ack_q  <= link.reg_req;
      run_out_q <= counting;
      if (rd)
        rdata_q <= rd_mux;
    end
  end

  // Outputs
  assign link.capture_flag_evt  = capture_flag_q;
  assign link.wrap_evt  = wrap_q;
  assign link.wo_pin    = pin_q;
  assign link.reg_ack   = ack_q;
  assign link.reg_rdata = rdata_q;
  assign count_o        = cnt_q;
  assign run_o          = run_out_q;

endmodule : tmb_timer_dev
`default_nettype wire

/* tmb_pkg.sv */
// Shared constants and types for the type B timer and its controller
package tmb_pkg;

  // ----------------------------------------------------------------
  // Device register indexes
  // ----------------------------------------------------------------
  localparam logic [2:0] DEV_CONTROL_A  = 3'h0;
  localparam logic [2:0] DEV_CONTROL_B  = 3'h1;
  localparam logic [2:0] DEV_EVENT_CONTROL = 3'h2;
  localparam logic [2:0] DEV_FLAGS  = 3'h3;
  localparam logic [2:0] DEV_STATUS = 3'h4;
  localparam logic [2:0] DEV_CNT    = 3'h5;
  localparam logic [2:0] DEV_COMPARE_CAPTURE_VALUE   = 3'h6;

  // ----------------------------------------------------------------
  // Device field positions
  // ----------------------------------------------------------------
  localparam int CONTROL_A_EN_BIT   = 0;
  localparam int CONTROL_A_CSEL_LSB = 1;
  localparam int CONTROL_B_MODE_LSB = 0;
  localparam int CONTROL_B_OEN_BIT  = 4;
  localparam int CONTROL_B_INIT_BIT = 5;
  localparam int EVENT_CONTROL_EI_BIT  = 0;
  localparam int EVENT_CONTROL_EDGE_BIT = 4;
  localparam int FLAG_CAPTURE_FLAG_BIT  = 0;
  localparam int FLAG_WRAP_BIT  = 1;
  localparam int STATUS_RUN_BIT = 0;

  // ----------------------------------------------------------------
  // Field encodings and count limits
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_PERIODIC = 2'h0;
  localparam logic [1:0]  MODE_TIMEOUT  = 2'h1;
  localparam logic [1:0]  MODE_CAPTURE  = 2'h2;
  localparam logic [1:0]  CSEL_DIV1     = 2'h0;
  localparam logic [1:0]  CSEL_DIV2     = 2'h1;
  localparam logic [1:0]  CSEL_COMP     = 2'h2;
  localparam logic [1:0]  CSEL_EVENT    = 2'h3;
  localparam logic [15:0] CNT_BOTTOM    = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [15:0] CNT_STEP      = 16'h0001;
  localparam logic [7:0]  REG8_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Controller APB map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] H_CMD   = 12'h000;
  localparam logic [11:0] H_WDATA = 12'h004;
  localparam logic [11:0] H_RDATA = 12'h008;
  localparam logic [11:0] H_STAT  = 12'h00c;
  localparam logic [11:0] H_PINS  = 12'h010;
  localparam int CMD_WR_BIT  = 8;
  localparam int CMD_BE_LSB  = 9;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CAPTURE_FLAG_BIT = 2;
  localparam int STAT_WRAP_BIT = 3;
  localparam int PINS_EVT_BIT  = 0;
  localparam int PINS_COMP_BIT = 1;
  localparam int PINS_PORT_BIT = 2;
  localparam logic [1:0] COMP_DIV_LAST = 2'h3;

  // Controller sequencer states
  typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} tmb_hst_t;

endpackage : tmb_pkg

/* tmb_link_if.sv */
// Link between the type B timer and its controller
`timescale 1ns/100ps
`default_nettype none
interface tmb_link_if;
  logic        reg_req;
  logic        reg_we;
  logic [2:0]  reg_addr;
  logic [1:0]  reg_be;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_ack;
  logic        evt_lvl;
  logic        comp_tick;
  logic        port_val;
  logic        capture_flag_evt;
  logic        wrap_evt;
  logic        wo_pin;

  // Timer end
  modport dev (
    input  reg_req, reg_we, reg_addr, reg_be, reg_wdata, evt_lvl, comp_tick, port_val,
    output reg_rdata, reg_ack, capture_flag_evt, wrap_evt, wo_pin
  );

  // Controller end
  modport ctl (
    output reg_req, reg_we, reg_addr, reg_be, reg_wdata, evt_lvl, comp_tick, port_val,
    input  reg_rdata, reg_ack, capture_flag_evt, wrap_evt, wo_pin
  );
endinterface : tmb_link_if
`default_nettype wire

/* tmb_edge_det.sv */
// Edge detector for the timer event input
`timescale 1ns/100ps
`default_nettype none
module tmb_edge_det (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic lvl_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic lvl_q;

  // Previous sample of the event level
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      lvl_q <= 1'b0;
    else
      lvl_q <= lvl_i;
  end

  // Edges need the level held over a clock edge
  assign rise_o = lvl_i & ~lvl_q;
  assign fall_o = ~lvl_i & lvl_q;

endmodule : tmb_edge_det
`default_nettype wire

/* tmb_ctl_host.sv */
// Controller end: APB registers drive the timer link
`timescale 1ns/100ps
`default_nettype none
module tmb_ctl_host (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  tmb_link_if.ctl          link
);

  tmb_pkg::tmb_hst_t st_q;
  logic [10:0]       cmd_q;
  logic [15:0]       wdata_q;
  logic [15:0]       rdata_q;
  logic [2:0]        pins_q;
  logic              done_q;
  logic              capture_flag_q;
  logic              wrap_q;
  logic [1:0]        div_q;
  logic              tick_q;
  logic [31:0]       prdata_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire sel_cmd  = paddr_i == tmb_pkg::H_CMD;
  wire sel_wd   = paddr_i == tmb_pkg::H_WDATA;
  wire sel_rd   = paddr_i == tmb_pkg::H_RDATA;
  wire sel_stat = paddr_i == tmb_pkg::H_STAT;
  wire sel_pins = paddr_i == tmb_pkg::H_PINS;
  wire hit      = sel_cmd | sel_wd | sel_rd | sel_stat | sel_pins;
  wire access   = psel_i & penable_i;
  wire apb_wr   = access & pwrite_i & hit;
  wire busy     = st_q != tmb_pkg::H_IDLE;
  wire go       = apb_wr & sel_cmd & ~busy;
  wire fin      = (st_q == tmb_pkg::H_WAIT) & link.reg_ack;
  wire stat_w1c = apb_wr & sel_stat;
  wire comp_end = pins_q[tmb_pkg::PINS_COMP_BIT] & (div_q == tmb_pkg::COMP_DIV_LAST);

  wire [31:0] rd_mux =
      sel_cmd  ? {21'h000000, cmd_q} :
      sel_wd   ? {16'h0000, wdata_q} :
      sel_rd   ? {16'h0000, rdata_q} :
      sel_stat ? {28'h0000000, wrap_q, capture_flag_q, done_q, busy} :
      sel_pins ? {29'h00000000, pins_q} : 32'h00000000;

  // Zero wait states, error on unmapped address
  assign pready_o  = access;
  assign pslverr_o = access & ~hit;
  assign prdata_o  = prdata_q;

  // ----------------------------------------------------------------
  // Link request sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      st_q <= tmb_pkg::H_IDLE;
    else
    begin
      unique case (st_q)
        tmb_pkg::H_IDLE: if (go) st_q <= tmb_pkg::H_REQ;
        tmb_pkg::H_REQ:  st_q <= tmb_pkg::H_WAIT;
        tmb_pkg::H_WAIT: if (link.reg_ack) st_q <= tmb_pkg::H_IDLE;
        default:         st_q <= tmb_pkg::H_IDLE;
      endcase
    end
  end

  // Software registers
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cmd_q    <= 11'h000;
      wdata_q  <= 16'h0000;
      pins_q   <= 3'h0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      if (go)
        cmd_q <= pwdata_i[10:0];
      if (apb_wr & sel_wd & ~busy)
        wdata_q <= pwdata_i[15:0];
      if (apb_wr & sel_pins)
        pins_q <= pwdata_i[2:0];
      if (psel_i & ~penable_i)
        prdata_q <= rd_mux;
    end
  end

  // Answer data, sticky status (set wins over clear), companion ticks
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_q <= 16'h0000;
      done_q  <= 1'b0;
      capture_flag_q  <= 1'b0;
      wrap_q  <= 1'b0;
      div_q   <= 2'h0;
      tick_q  <= 1'b0;
    end
    else
    begin
      if (fin & ~cmd_q[tmb_pkg::CMD_WR_BIT])
        rdata_q <= link.reg_rdata;
      done_q <= (done_q & ~(stat_w1c & pwdata_i[tmb_pkg::STAT_DONE_BIT])) | fin;
      capture_flag_q <= (capture_flag_q & ~(stat_w1c & pwdata_i[tmb_pkg::STAT_CAPTURE_FLAG_BIT])) | link.capture_flag_evt;
      wrap_q <= (wrap_q & ~(stat_w1c & pwdata_i[tmb_pkg::STAT_WRAP_BIT])) | link.wrap_evt;
      div_q  <= pins_q[tmb_pkg::PINS_COMP_BIT] ? div_q + 2'h1 : 2'h0;
      tick_q <= comp_end;
    end
  end

  // Link drive
  assign link.reg_req   = st_q == tmb_pkg::H_REQ;
  assign link.reg_we    = cmd_q[tmb_pkg::CMD_WR_BIT];
  assign link.reg_addr  = cmd_q[2:0];
  assign link.reg_be    = cmd_q[tmb_pkg::CMD_BE_LSB +: 2];
  assign link.reg_wdata = wdata_q;
  assign link.evt_lvl   = pins_q[tmb_pkg::PINS_EVT_BIT];
  assign link.port_val  = pins_q[tmb_pkg::PINS_PORT_BIT];
  assign link.comp_tick = tick_q;

endmodule : tmb_ctl_host
`default_nettype wire

/* tmb_link_assertions.sv */
// Link and pin checks for the type B timer pair
`timescale 1ns/100ps
`default_nettype none
module tmb_link_assertions (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        reg_req,
  input wire logic        reg_we,
  input wire logic [2:0]  reg_addr,
  input wire logic [1:0]  reg_be,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        port_val,
  input wire logic        capture_flag_evt,
  input wire logic        wrap_evt,
  input wire logic        wo_pin
);
  // ------------------
  // Control shadows
  // ------------------
  logic en_q;
  logic oen_q;
  logic init_q;
  wire  a_wr = reg_req && reg_we && reg_be[0] && (reg_addr == tmb_pkg::DEV_CONTROL_A);
  wire  b_wr = reg_req && reg_we && reg_be[0] && (reg_addr == tmb_pkg::DEV_CONTROL_B);

  // Follow enable and output writes
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      en_q   <= 1'b0;
      oen_q  <= 1'b0;
      init_q <= 1'b0;
    end
    else
    begin
      if (a_wr)
        en_q <= reg_wdata[tmb_pkg::CONTROL_A_EN_BIT];
      if (b_wr)
        oen_q <= reg_wdata[tmb_pkg::CONTROL_B_OEN_BIT];
      if (b_wr)
        init_q <= reg_wdata[tmb_pkg::CONTROL_B_INIT_BIT];
    end
  end

  // ------------------
  // Properties
  // ------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  ack_after_req_a : assert property (reg_req |=> reg_ack)
    else $error("no ack after link request");
  ack_has_req_a : assert property (reg_ack |-> $past(reg_req))
    else $error("ack without request");
  req_single_a : assert property (reg_req |=> !reg_req)
    else $error("request longer than one cycle");
  wrap_single_a : assert property (wrap_evt |=> !wrap_evt)
    else $error("wrap event longer than one cycle");
  idle_quiet_a : assert property (!en_q && !$past(en_q, 2) |-> !capture_flag_evt && !wrap_evt)
    else $error("event while disabled");
  wo_port_a : assert property (!oen_q && !$past(oen_q, 3) && $stable(port_val)
    |-> wo_pin == port_val)
    else $error("pin does not follow port value");
  wo_init_a : assert property (oen_q && $past(oen_q, 3) && ($past(init_q, 3) == init_q)
    |-> wo_pin == init_q)
    else $error("pin does not show initial level");
  unmapped_zero_a : assert property (reg_req && !reg_we && reg_addr == 3'h7
    |=> reg_rdata == 16'h0000)
    else $error("unmapped index read not zero");
endmodule : tmb_link_assertions
`default_nettype wire

/* test_timer_b_count_capture.sv */
// Self-checking bench for the type B timer and its APB controller
`timescale 1ns/100ps
`default_nettype none
module test_timer_b_count_capture;
  typedef struct {logic [2:0] i; logic [15:0] d; logic [15:0] e;} tmb_row_t;
  logic        clk_i, rstn_i, psel, penable, pwrite, serr, pready, pslverr, run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, c;
  logic [15:0] count;
  int          bad_count, cmp_count;
  tmb_row_t    rows [4];

  tmb_link_if link ();
  tmb_timer_dev tmb_timer_dev_i (.clk_i(clk_i), .rstn_i(rstn_i), .link(link.dev),
    .count_o(count), .run_o(run));
  tmb_ctl_host tmb_ctl_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link.ctl));
  tmb_link_assertions tmb_link_assertions_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .reg_req(link.reg_req), .reg_we(link.reg_we), .reg_addr(link.reg_addr),
    .reg_be(link.reg_be), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .reg_ack(link.reg_ack), .port_val(link.port_val), .capture_flag_evt(link.capture_flag_evt),
    .wrap_evt(link.wrap_evt), .wo_pin(link.wo_pin));

  // ------------------
  // Tasks
  // ------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One APB transfer, result in r and serr
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      chk(32'h0, 32'h1);
    if (pready !== 1'b1)
      complete_run();
  endtask : apb

  // Poll a status bit until it reaches v
  task automatic stw(input int b, input logic v);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, tmb_pkg::H_STAT, 32'h0);
      k++;
    end while (r[b] !== v && k < 200);
    chk({31'h0, r[b]}, {31'h0, v});
    if (r[b] !== v)
      complete_run();
  endtask : stw

  task automatic dev_wr(input logic [2:0] i, input logic [15:0] d);
    apb(1'b1, tmb_pkg::H_WDATA, {16'h0, d});
    apb(1'b1, tmb_pkg::H_CMD, {29'he0, i});
    stw(tmb_pkg::STAT_BUSY_BIT, 1'b0);
  endtask : dev_wr

  task automatic dev_rd(input logic [2:0] i);
    apb(1'b1, tmb_pkg::H_CMD, {29'hc0, i});
    stw(tmb_pkg::STAT_BUSY_BIT, 1'b0);
    apb(1'b0, tmb_pkg::H_RDATA, 32'h0);
  endtask : dev_rd

  task automatic pins(input logic [31:0] v);
    apb(1'b1, tmb_pkg::H_PINS, v);
  endtask : pins

  // ------------------
  // Sequence
  // ------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    cmp_count = 0;
    rows = '{'{3'h6, 16'h1234, 16'h1234}, '{3'h5, 16'h00ab, 16'h00ab},
             '{3'h4, 16'h0001, 16'h0000}, '{3'h2, 16'h0011, 16'h0011}};
    rstn_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      dev_rd(i[2:0]);
      chk(r, 32'h0);
    end
    foreach (rows[i])
    begin
      dev_wr(rows[i].i, rows[i].d);
      dev_rd(rows[i].i);
      chk(r, {16'h0, rows[i].e});
    end
    // Periodic count to top, then from a count written above top on to max
    dev_wr(3'h2, 16'h0001);
    dev_wr(3'h6, 16'h0010);
    dev_wr(3'h5, 16'h0000);
    apb(1'b1, tmb_pkg::H_STAT, 32'he);
    dev_wr(3'h0, 16'h0001);
    stw(2, 1'b1);
    chk({31'h0, r[3]}, 32'h0);
    dev_rd(3'h5);
    chk({31'h0, r <= 32'h10}, 32'h1);
    dev_wr(3'h5, 16'hfff0);
    stw(3, 1'b1);
    dev_rd(3'h3);
    chk(r, 32'h3);
    // Event channel as counting clock, stopped while the count is cleared
    dev_wr(3'h0, 16'h0006);
    dev_wr(3'h5, 16'h0000);
    dev_wr(3'h0, 16'h0007);
    repeat (3)
    begin
      pins(32'h1);
      pins(32'h0);
    end
    chk({16'h0, count}, 32'h3);
    // Companion ticks step the count only while the companion pin is set
    dev_wr(3'h5, 16'h0000);
    dev_wr(3'h0, 16'h0005);
    chk({16'h0, count}, 32'h0);
    pins(32'h2);
    repeat (20) @(posedge clk_i);
    pins(32'h0);
    chk({31'h0, count >= 16'h4 && count <= 16'h8}, 32'h1);
    // Halved peripheral clock: one step every second cycle
    dev_wr(3'h6, 16'h1000);
    dev_wr(3'h0, 16'h0003);
    c = {16'h0, count};
    repeat (20) @(posedge clk_i);
    chk({16'h0, count - c[15:0]}, 32'ha);
    // Time-out: start, stop, frozen, inverted edges
    dev_wr(3'h0, 16'h0000);
    dev_wr(3'h1, 16'h0001);
    dev_wr(3'h6, 16'h1000);
    dev_wr(3'h0, 16'h0001);
    chk({31'h0, run}, 32'h0);
    pins(32'h1);
    dev_rd(3'h4);
    chk(r, 32'h1);
    pins(32'h0);
    dev_rd(3'h5);
    c = r;
    dev_wr(3'h4, 16'h0001);
    dev_rd(3'h6);
    dev_rd(3'h4);
    chk(r, 32'h0);
    dev_rd(3'h5);
    chk(r, c);
    dev_wr(3'h2, 16'h0011);
    dev_wr(3'h6, 16'h0040);
    apb(1'b1, tmb_pkg::H_STAT, 32'he);
    pins(32'h1);
    repeat (3) @(posedge clk_i);
    chk({31'h0, run}, 32'h0);
    pins(32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, run}, 32'h1);
    stw(2, 1'b1);
    // Capture on rising, then on falling edge
    dev_wr(3'h0, 16'h0000);
    dev_wr(3'h1, 16'h0002);
    dev_wr(3'h2, 16'h0001);
    dev_wr(3'h5, 16'h0000);
    dev_wr(3'h3, 16'h0003);
    dev_wr(3'h0, 16'h0001);
    pins(32'h1);
    dev_rd(3'h3);
    chk(r, 32'h1);
    dev_rd(3'h6);
    c = r;
    chk({31'h0, c != 32'h0}, 32'h1);
    dev_rd(3'h3);
    chk(r, 32'h0);
    pins(32'h0);
    dev_rd(3'h6);
    chk(r, c);
    dev_wr(3'h2, 16'h0011);
    pins(32'h1);
    pins(32'h0);
    dev_rd(3'h6);
    chk({31'h0, r > c}, 32'h1);
    apb(1'b1, tmb_pkg::H_STAT, 32'he);
    dev_wr(3'h5, 16'hfff8);
    stw(3, 1'b1);
    // Pin: port value, then waveform override
    dev_wr(3'h0, 16'h0000);
    dev_wr(3'h1, 16'h0000);
    pins(32'h4);
    repeat (3) @(posedge clk_i);
    chk({31'h0, link.wo_pin}, 32'h1);
    dev_wr(3'h1, 16'h0010);
    chk({31'h0, link.wo_pin}, 32'h0);
    dev_wr(3'h1, 16'h0030);
    pins(32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, link.wo_pin}, 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, serr}, 32'h1);
    // Reset in mid-run
    rstn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    dev_rd(3'h1);
    chk(r, 32'h0);
    complete_run();
  end
endmodule : test_timer_b_count_capture
`default_nettype wire
